// ==== blk_pkg.sv ====
/*
 * Shared constants and carriers for the logic array block.
 * Assumes one 100 MHz clock and an APB master with 32-bit data.
 */
package blk_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_LE  = 4;	// Elements served
	localparam int NUM_SRC = 4;	// Lines per source kind
	localparam int NUM_CH  = 2;	// Clock and enable pairs
	localparam logic [3:0] MAX_CTL = 4'h6;

	// ****************************************
	// Source kinds, modes, async actions
	// ****************************************
	localparam logic [1:0] SRC_NONE   = 2'h0;
	localparam logic [1:0] SRC_LOCAL  = 2'h1;
	localparam logic [1:0] SRC_GLOBAL = 2'h2;
	localparam logic [1:0] SRC_PIN    = 2'h3;
	localparam logic [2:0] MODE_NORMAL = 3'h1;
	localparam logic [2:0] MODE_ARITH  = 3'h2;
	localparam logic [2:0] MODE_COUNT  = 3'h4;
	localparam logic [1:0] ACT_CLEAR  = 2'h0;
	localparam logic [1:0] ACT_PRESET = 2'h1;
	localparam logic [1:0] ACT_LOAD   = 2'h2;
	localparam logic [1:0] LINE_FIRST  = 2'h1;
	localparam logic [1:0] LINE_SECOND = 2'h2;

	// ****************************************
	// Register map and field positions
	// ****************************************
	localparam logic [7:0] OFF_CHAN  = 8'h00;
	localparam logic [7:0] OFF_CTRL  = 8'h04;
	localparam logic [7:0] OFF_LE    = 8'h08;
	localparam logic [7:0] OFF_LUT01 = 8'h0C;
	localparam logic [7:0] OFF_LUT23 = 8'h10;
	localparam logic [7:0] OFF_STAT  = 8'h14;
	localparam int CH1_LSB  = 16;
	localparam int ERR_BIT  = 4;
	localparam int CNT_LSB  = 8;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [1:0] kind;
		logic [1:0] idx;
	} src_t;

	typedef struct packed {
		src_t ena;
		logic fall;
		src_t clk;
	} chan_t;

	typedef struct packed {
		src_t sload;
		src_t sclr;
		src_t aclr2;
		src_t aclr1;
	} ctl_cfg_t;

	typedef struct packed {
		logic [1:0] act;
		logic [1:0] line;
		logic       ch;
		logic [2:0] mode;
	} le_cfg_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

endpackage

// ==== pin_sync.sv ====
/*
 * Three-stage synchroniser for lines from outside the clock domain.
 * Assumes reset already synchronised to clk_i.
 */
`timescale 1ns/1ps
module pin_sync
	import blk_pkg::*;
#(
	parameter int WIDTH = 4
)(
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Lines
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] level_o
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] val;
	} sync_st_t;

	sync_st_t st;
	sync_st_t next_st;

	// A change counts only once stages two and three agree
	always_comb
	begin
		next_st    = st;
		next_st.s1 = async_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st.s2[i] == st.s3[i])
				next_st.val[i] = st.s3[i];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign level_o = st.val;

endmodule

// ==== logic_element.sv ====
/*
 * One logic element: look-up, carry and cascade, and its register.
 * Assumes fire_i is already the paired clock tick and enable.
 */
`timescale 1ns/1ps
module logic_element
	import blk_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Configuration
	input  wire le_cfg_t    cfg_i,
	input  wire logic [15:0] lut_i,
	// Seven inputs less feedback
	input  wire logic [3:0] data_i,
	input  wire logic       carry_in_i,
	input  wire logic       cascade_in_i,
	// Block-wide controls
	input  wire logic       fire_i,
	input  wire logic       sclr_i,
	input  wire logic       sload_i,
	input  wire logic       async_i,
	// Results
	output logic            out_o,
	output logic            q_o,
	output logic            carry_out_o,
	output logic            cascade_out_o
);

	typedef struct packed {
		logic q;
	} le_st_t;

	le_st_t st;
	le_st_t next_st;
	logic   comb;
	logic   async_val;

	// Mode steers the seven inputs
	always_comb
	begin
		comb          = lut_i[data_i] & cascade_in_i;
		carry_out_o   = 1'b0;
		cascade_out_o = comb;
		case (cfg_i.mode)
			MODE_ARITH:
			begin
				comb        = data_i[0] ^ data_i[1] ^ carry_in_i;
				carry_out_o = (data_i[0] & data_i[1]) |
					(carry_in_i & (data_i[0] ^ data_i[1]));
			end
			MODE_COUNT:
			begin
				comb        = st.q ^ carry_in_i;
				carry_out_o = st.q & carry_in_i;
			end
			default: ;
		endcase
	end

	// Async line acts as clear, preset or load
	always_comb
	begin
		case (cfg_i.act)
			ACT_PRESET: async_val = 1'b1;
			ACT_LOAD:   async_val = data_i[3];
			default:    async_val = 1'b0;
		endcase
	end

	// Same control path in every mode
	always_comb
	begin
		next_st = st;
		if (async_i)
			next_st.q = async_val;
		else if (fire_i)
		begin
			if (sclr_i)
				next_st.q = 1'b0;
			else if (sload_i)
				next_st.q = data_i[3];
			else
				next_st.q = comb;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st <= '0;
		else
			st <= next_st;
	end

	// Async override shows at once, not a cycle later
	assign out_o = async_i ? async_val : st.q;
	assign q_o   = st.q;

endmodule

// ==== logic_array_block.sv ====
/*
 * Control-signal generation for one logic array block, with its
 * elements and an APB register file.
 * Assumes an APB master on clk_i; pins and global lines are async.
 */
`timescale 1ns/1ps
module logic_array_block
	import blk_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	// APB slave
	input  wire apb_req_t                 apb_i,
	output apb_rsp_t                      apb_o,
	// Control sources
	input  wire logic [NUM_SRC-1:0]       local_ctl_i,
	input  wire logic [NUM_SRC-1:0]       global_i,
	input  wire logic [NUM_SRC-1:0]       clk_pin_i,
	// Element data
	input  wire logic [NUM_LE-1:0][3:0]   le_data_i,
	input  wire logic                     carry_in_i,
	input  wire logic                     cascade_in_i,
	// Element results
	output logic      [NUM_LE-1:0]        le_out_o,
	output logic                          carry_out_o,
	output logic                          cascade_out_o,
	// Block-wide controls
	output logic                          block_clock_first_o,
	output logic                          block_clock_second_o,
	output logic                          block_clock_enable_first_o,
	output logic                          block_async_clear_first_o,
	output logic                          block_async_clear_second_o,
	output logic                          block_sync_clear_o
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		chan_t [NUM_CH-1:0]       chan;
		ctl_cfg_t                 ctl;
		le_cfg_t [NUM_LE-1:0]     le;
		logic [NUM_LE-1:0][15:0]  lut;
		logic                     err;
		logic [NUM_CH-1:0]        prev;
		logic [31:0]              rdata;
		logic                     slverr;
	} blk_st_t;

	blk_st_t st;
	blk_st_t next_st;

	logic [1:0]          rst_pipe;
	logic                rst_n;
	logic [NUM_SRC-1:0]  glb;
	logic [NUM_SRC-1:0]  pin;
	logic [NUM_CH-1:0]   clk_lvl;
	logic [NUM_CH-1:0]   tick;
	logic [NUM_CH-1:0]   ena;
	logic [NUM_CH-1:0]   fire;
	logic [1:0]          aclr;
	logic                sclr;
	logic                sload;
	logic [NUM_LE-1:0]   le_fire;
	logic [NUM_LE-1:0]   le_async;
	logic [NUM_LE-1:0]   le_q;
	logic [NUM_LE:0]     carry;
	logic [NUM_LE:0]     cascade;
	logic                setup;
	logic                access;
	logic                wr_take;
	logic                hit;
	logic [31:0]         rd_val;
	chan_t [NUM_CH-1:0]  cand_chan;
	ctl_cfg_t            cand_ctl;
	logic [3:0]          used_cnt;
	logic [3:0]          cand_cnt;
	logic                cfg_ok;

	// ****************************************
	// Reset release
	// ****************************************
	// Two flops so release never lands mid-cycle in the block
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end

	assign rst_n = rst_pipe[1];

	// ****************************************
	// Source synchronisers
	// ****************************************
	// Global lines and the four dedicated pins
	pin_sync #(.WIDTH(NUM_SRC)) u_glb_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.async_i (global_i),
		.level_o (glb)
	);

	pin_sync #(.WIDTH(NUM_SRC)) u_pin_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.async_i (clk_pin_i),
		.level_o (pin)
	);

	// ****************************************
	// Helpers
	// ****************************************
	// Pick one line of local, global or pin sources
	function automatic logic src_lvl(input src_t s,
		input logic [NUM_SRC-1:0] loc,
		input logic [NUM_SRC-1:0] g,
		input logic [NUM_SRC-1:0] p);
		case (s.kind)
			SRC_LOCAL:  src_lvl = loc[s.idx];
			SRC_GLOBAL: src_lvl = g[s.idx];
			SRC_PIN:    src_lvl = p[s.idx];
			default:    src_lvl = 1'b0;
		endcase
	endfunction

	// Controls that a configuration puts in use
	function automatic logic [3:0] count_ctl(
		input chan_t [NUM_CH-1:0] c,
		input ctl_cfg_t k);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < NUM_CH; i++)
		begin
			n = n + {3'h0, c[i].clk.kind != SRC_NONE};
			n = n + {3'h0, c[i].ena.kind != SRC_NONE};
		end
		n = n + {3'h0, k.aclr1.kind != SRC_NONE};
		n = n + {3'h0, k.aclr2.kind != SRC_NONE};
		n = n + {3'h0, k.sclr.kind != SRC_NONE};
		n = n + {3'h0, k.sload.kind != SRC_NONE};
		return n;
	endfunction

	// ****************************************
	// Block-wide control generation
	// ****************************************
	// Two independent channels, each edge chosen per channel
	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			clk_lvl[c] = src_lvl(st.chan[c].clk, local_ctl_i, glb, pin);
			// Both edges of one clock need both channels
			tick[c] = (st.chan[c].clk.kind != SRC_NONE) &&
				(st.chan[c].fall ? (st.prev[c] && !clk_lvl[c])
				                 : (!st.prev[c] && clk_lvl[c]));
			// An unused enable leaves the channel always enabled
			ena[c] = (st.chan[c].ena.kind == SRC_NONE) ||
				src_lvl(st.chan[c].ena, local_ctl_i, glb, pin);
			fire[c] = tick[c] && ena[c];
		end
	end

	// Async and sync controls
	always_comb
	begin
		aclr[0] = src_lvl(st.ctl.aclr1, local_ctl_i, glb, pin);
		aclr[1] = src_lvl(st.ctl.aclr2, local_ctl_i, glb, pin);
		sclr    = src_lvl(st.ctl.sclr, local_ctl_i, glb, pin);
		sload   = src_lvl(st.ctl.sload, local_ctl_i, glb, pin);
	end

	// Element picks a channel, never a clock apart from its enable
	always_comb
	begin
		for (int i = 0; i < NUM_LE; i++)
		begin
			le_fire[i] = fire[st.le[i].ch];
			case (st.le[i].line)
				LINE_FIRST:  le_async[i] = aclr[0];
				LINE_SECOND: le_async[i] = aclr[1];
				default:     le_async[i] = 1'b0;
			endcase
		end
	end

	assign block_clock_first_o        = tick[0];
	assign block_clock_second_o       = tick[1];
	assign block_clock_enable_first_o = ena[0];
	assign block_async_clear_first_o  = aclr[0];
	assign block_async_clear_second_o = aclr[1];
	assign block_sync_clear_o         = sclr;

	// ****************************************
	// Elements
	// ****************************************
	assign carry[0]   = carry_in_i;
	assign cascade[0] = cascade_in_i;

	generate
		for (genvar i = 0; i < NUM_LE; i++)
		begin : g_le
			logic_element u_le (
				.clk_i         (clk_i),
				.rst_n_i       (rst_n),
				.cfg_i         (st.le[i]),
				.lut_i         (st.lut[i]),
				.data_i        (le_data_i[i]),
				.carry_in_i    (carry[i]),
				.cascade_in_i  (cascade[i]),
				.fire_i        (le_fire[i]),
				.sclr_i        (sclr),
				.sload_i       (sload),
				.async_i       (le_async[i]),
				.out_o         (le_out_o[i]),
				.q_o           (le_q[i]),
				.carry_out_o   (carry[i+1]),
				.cascade_out_o (cascade[i+1])
			);
		end
	endgenerate

	assign carry_out_o   = carry[NUM_LE];
	assign cascade_out_o = cascade[NUM_LE];

	// ****************************************
	// APB slave
	// ****************************************
	assign setup   = apb_i.psel && !apb_i.penable;
	assign access  = apb_i.psel && apb_i.penable;
	assign wr_take = access && apb_i.pwrite;

	// Candidate configuration of a write, checked before it lands
	always_comb
	begin
		cand_chan = st.chan;
		cand_ctl  = st.ctl;
		if (wr_take && apb_i.paddr == OFF_CHAN)
		begin
			cand_chan[0] = chan_t'(apb_i.pwdata[8:0]);
			cand_chan[1] = chan_t'(apb_i.pwdata[CH1_LSB+8:CH1_LSB]);
		end
		else if (wr_take && apb_i.paddr == OFF_CTRL)
			cand_ctl = ctl_cfg_t'(apb_i.pwdata[15:0]);
		cand_cnt = count_ctl(cand_chan, cand_ctl);
		used_cnt = count_ctl(st.chan, st.ctl);
		// Over six, or sync controls on a pin, is refused
		cfg_ok = (cand_cnt <= MAX_CTL) &&
			(cand_ctl.sclr.kind != SRC_PIN) &&
			(cand_ctl.sload.kind != SRC_PIN);
	end

	// Read decode; unmapped addresses answer with an error
	always_comb
	begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		if (apb_i.paddr == OFF_CHAN)
		begin
			rd_val[8:0]               = st.chan[0];
			rd_val[CH1_LSB+8:CH1_LSB] = st.chan[1];
		end
		else if (apb_i.paddr == OFF_CTRL)
			rd_val[15:0] = st.ctl;
		else if (apb_i.paddr == OFF_LE)
			rd_val = st.le;
		else if (apb_i.paddr == OFF_LUT01)
			rd_val = {st.lut[1], st.lut[0]};
		else if (apb_i.paddr == OFF_LUT23)
			rd_val = {st.lut[3], st.lut[2]};
		else if (apb_i.paddr == OFF_STAT)
		begin
			rd_val[NUM_LE-1:0]       = le_q;
			rd_val[ERR_BIT]          = st.err;
			rd_val[CNT_LSB+3:CNT_LSB] = used_cnt;
		end
		else
			hit = 1'b0;
	end

	// Register update; a refused write sets the sticky error
	always_comb
	begin
		next_st      = st;
		next_st.prev = clk_lvl;
		if (setup)
		begin
			next_st.rdata  = rd_val;
			next_st.slverr = !hit;
		end
		if (wr_take)
		begin
			if (apb_i.paddr == OFF_CHAN || apb_i.paddr == OFF_CTRL)
			begin
				if (cfg_ok)
				begin
					next_st.chan = cand_chan;
					next_st.ctl  = cand_ctl;
				end
				else
					next_st.err = 1'b1;
			end
			else if (apb_i.paddr == OFF_LE)
				next_st.le = apb_i.pwdata;
			else if (apb_i.paddr == OFF_LUT01)
				next_st.lut[1:0] = apb_i.pwdata;
			else if (apb_i.paddr == OFF_LUT23)
				next_st.lut[3:2] = apb_i.pwdata;
			else if (apb_i.paddr == OFF_STAT && apb_i.pwdata[ERR_BIT])
				next_st.err = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			st <= blk_st_t'(CFG_RST);
		else
			st <= next_st;
	end

	// One wait-free access phase; read data held in a flop
	assign apb_o.pready  = access;
	assign apb_o.pslverr = access && st.slverr;
	assign apb_o.prdata  = st.rdata;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	ctl_limit_a: assert property (used_cnt <= MAX_CTL)
		else $error("more than six controls in use");

	cfg_refuse_a: assert property (wr_take && !cfg_ok
		&& apb_i.paddr == OFF_CTRL
		|=> $stable(st.ctl) && st.err)
		else $error("refused write changed config");

	sclr_src_a: assert property (st.ctl.sclr.kind != SRC_PIN)
		else $error("sync clear sourced from a pin");

	enable_pair_a: assert property (tick[0] && !ena[0]
		&& !st.le[0].ch && !le_async[0] |=> $stable(le_q[0]))
		else $error("channel fired with its enable low");

	edge_pol_a: assert property (tick[1] |->
		clk_lvl[1] == !st.chan[1].fall &&
		$past(clk_lvl[1]) == st.chan[1].fall)
		else $error("tick on wrong edge");

	le_hold_a: assert property (!le_fire[0] && !le_async[0]
		|=> $stable(le_q[0]))
		else $error("register moved without edge");

	async_now_a: assert property (le_async[0]
		&& st.le[0].act == ACT_CLEAR |-> le_out_o[0] == 1'b0)
		else $error("async clear not immediate");

	arith_carry_a: assert property (st.le[1].mode == MODE_ARITH
		|-> carry[2] == ((le_data_i[1][0] & le_data_i[1][1]) |
		(carry[1] & (le_data_i[1][0] ^ le_data_i[1][1]))))
		else $error("arithmetic carry wrong");

	count_step_a: assert property (st.le[0].mode == MODE_COUNT
		&& le_fire[0] && !le_async[0] && !sclr && !sload
		|=> le_q[0] == ($past(le_q[0]) ^ $past(carry_in_i)))
		else $error("counter step wrong");

	both_fire_c: cover property (fire[0] && fire[1]);
	refuse_c: cover property (wr_take && !cfg_ok);
	async_c: cover property (le_async[0] [*3]);
	count_c: cover property (st.le[0].mode == MODE_COUNT && le_fire[0]);

endmodule

// ==== route_model.sv ====
/*
 * Far-side model: routing, global and pin lines that feed the
 * block's control selectors.
 * Assumes the testbench steps it through set_line on clk_i.
 */
`timescale 1ns/1ps
module route_model
	import blk_pkg::*;
(
	// Clock
	input  wire logic               clk_i,
	// Source lines
	output logic      [NUM_SRC-1:0] local_ctl_o,
	output logic      [NUM_SRC-1:0] global_o,
	output logic      [NUM_SRC-1:0] clk_pin_o
);
	// ****************************************
	// Line driving
	// ****************************************
	// All lines idle low; they are levels, never released
	initial
	begin
		local_ctl_o = '0;
		global_o = '0;
		clk_pin_o = '0;
	end

	// Move one line just after an edge so no sample races it
	task automatic set_line(input src_t s, input logic v);
	begin
		@(posedge clk_i);
		case (s.kind)
			SRC_LOCAL: local_ctl_o[s.idx] <= v;
			SRC_GLOBAL: global_o[s.idx] <= v;
			SRC_PIN: clk_pin_o[s.idx] <= v;
			default: ;
		endcase
	end
	endtask
endmodule

// ==== logic_array_block_tb.sv ====
/*
 * Self-checking bench for the logic array block control logic.
 * Assumes route_model drives the source lines and APB is 0-wait.
 */
`timescale 1ns/1ps
module logic_array_block_tb
	import blk_pkg::*;
;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] r;
		logic        e;
	} row_t;

	logic                   clk_i;
	logic                   rstn_i;
	apb_req_t               req;
	apb_rsp_t               rsp;
	logic [NUM_SRC-1:0]     loc, glb, pin;
	logic [NUM_LE-1:0][3:0] le_data;
	logic [NUM_LE-1:0]      le_out;
	logic                   cin, cas, ck1, ck2, en1, ac1, ac2, sclr, co, cso;
	int                     fails, num_checks, n1, n2, c1, c2, cyc, i;
	logic [31:0]            r;
	logic                   e;
	logic [3:0]             srcs [6] = '{4'h4, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
	logic [7:0]             acts [3] = '{8'h11, 8'h51, 8'h94};
	logic                   aexp [3] = '{1'b0, 1'b1, 1'b0};
	row_t                   rows [6] = '{
		'{OFF_CHAN, 32'h0014_00A4, 32'h0014_00A4, 1'b0},
		'{OFF_CTRL, 32'h0000_0086, 32'h0000_0086, 1'b0},
		'{OFF_LE, 32'h0403_0201, 32'h0403_0201, 1'b0},
		'{OFF_LUT01, 32'h1234_8000, 32'h1234_8000, 1'b0},
		'{OFF_LUT23, 32'hFFFF_0000, 32'hFFFF_0000, 1'b0},
		'{8'h18, 32'h5A5A_5A5A, 32'h0000_0000, 1'b1}};

	// ****************************************
	// Instances
	// ****************************************
	route_model far (.clk_i(clk_i), .local_ctl_o(loc), .global_o(glb),
		.clk_pin_o(pin));

	logic_array_block dut (.clk_i(clk_i), .rstn_i(rstn_i), .apb_i(req),
		.apb_o(rsp), .local_ctl_i(loc), .global_i(glb),
		.clk_pin_i(pin), .le_data_i(le_data), .carry_in_i(cin),
		.cascade_in_i(cas), .le_out_o(le_out), .carry_out_o(co),
		.cascade_out_o(cso), .block_clock_first_o(ck1),
		.block_clock_second_o(ck2), .block_clock_enable_first_o(en1),
		.block_async_clear_first_o(ac1),
		.block_async_clear_second_o(ac2), .block_sync_clear_o(sclr));

	// ****************************************
	// Clock, tick counters, timeout
	// ****************************************
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Ticks are one cycle wide, so count them at every edge
	always @(posedge clk_i)
	begin
		n1 += ck1;
		n2 += ck2;
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			summarize();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	begin
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	end
	endtask

	// One APB transfer; only the bench timeout ends a hung wait
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
	begin
		@(posedge clk_i);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do
			@(posedge clk_i);
		while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
	begin
		apb(1'b0, a, 32'h0);
		chk(r & m, x);
	end
	endtask

	// Synchronised lines need up to four edges plus the edge detect
	task automatic line(input logic [3:0] s, input logic v, input int n);
	begin
		far.set_line(s, v);
		repeat (n) @(posedge clk_i);
	end
	endtask

	task automatic summarize();
	begin
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{fails, num_checks, n1, n2, cyc} = '0;
		rstn_i = 1'b0;
		req = '0;
		le_data = '0;
		cin = 1'b0;
		cas = 1'b1;
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(en1, 1'b1);
		for (i = 0; i < 5; i++)
			rdchk(rows[i].a, 32'hFFFF_FFFF, CFG_RST);
		// Table: write, then read back with the response code
		for (i = 0; i < 6; i++)
		begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk(e, rows[i].e);
			apb(1'b0, rows[i].a, 32'h0);
			chk(r, rows[i].r);
			chk(e, rows[i].e);
		end
		rdchk(OFF_STAT, 32'hF00, 32'h500);
		// Seven controls in use must be refused
		apb(1'b1, OFF_CTRL, 32'h8786);
		rdchk(OFF_CTRL, 32'hFFFF_FFFF, 32'h86);
		rdchk(OFF_STAT, 32'h10, 32'h10);
		apb(1'b1, OFF_STAT, 32'h10);
		rdchk(OFF_STAT, 32'h10, 32'h0);
		// Sync clear from a pin is refused, from global taken
		apb(1'b1, OFF_CTRL, 32'h0C86);
		rdchk(OFF_CTRL, 32'hFFFF_FFFF, 32'h86);
		rdchk(OFF_STAT, 32'h10, 32'h10);
		apb(1'b1, OFF_STAT, 32'h10);
		apb(1'b1, OFF_CTRL, 32'h0986);
		rdchk(OFF_CTRL, 32'hFFFF_FFFF, 32'h986);
		rdchk(OFF_STAT, 32'hF10, 32'h600);
		// Element 0 on channel 0, look-up true only for data F
		apb(1'b1, OFF_LE, 32'h01);
		apb(1'b1, OFF_LUT01, 32'h8000);
		le_data[0] <= 4'hF;
		line(4'h5, 1'b1, 8);
		c1 = n1;
		c2 = n2;
		line(4'h4, 1'b1, 8);
		chk(n1 - c1, 1);
		chk(n2 - c2, 0);
		chk(le_out[0], 1'b1);
		c1 = n1;
		c2 = n2;
		line(4'h4, 1'b0, 8);
		chk(n1 - c1, 0);
		chk(n2 - c2, 1);
		// Enable low holds the register on a clock tick
		le_data[0] <= 4'h0;
		line(4'h5, 1'b0, 8);
		line(4'h4, 1'b1, 8);
		chk(le_out[0], 1'b1);
		line(4'h4, 1'b0, 8);
		line(4'h5, 1'b1, 8);
		line(4'h4, 1'b1, 8);
		chk(le_out[0], 1'b0);
		// Sync clear beats the look-up on an enabled tick
		le_data[0] <= 4'hF;
		line(4'h4, 1'b0, 8);
		line(4'h9, 1'b1, 8);
		chk(sclr, 1'b1);
		line(4'h4, 1'b1, 8);
		chk(le_out[0], 1'b0);
		line(4'h9, 1'b0, 8);
		line(4'h4, 1'b0, 8);
		line(4'h4, 1'b1, 8);
		chk(le_out[0], 1'b1);
		// Async clear, preset and load from the first line, then preset from the second
		le_data[0] <= 4'h7;
		for (i = 0; i < 3; i++)
		begin
			apb(1'b1, OFF_LE, {24'h0, acts[i]});
			line(4'h6, 1'b1, 1);
			chk(ac1, 1'b1);
			chk(le_out[0], aexp[i]);
			line(4'h6, 1'b0, 2);
		end
		apb(1'b1, OFF_LE, 32'h61);
		line(4'h8, 1'b1, 8);
		chk(ac2, 1'b1);
		chk(le_out[0], 1'b1);
		line(4'h8, 1'b0, 8);
		// Local line 0 low again so each source below starts idle
		line(4'h4, 1'b0, 8);
		// Channel 0 clock from local, global and all four pins
		for (i = 0; i < 6; i++)
		begin
			apb(1'b1, OFF_CHAN, 32'h0014_00A0 | srcs[i]);
			c1 = n1;
			line(srcs[i], 1'b1, 8);
			line(srcs[i], 1'b0, 8);
			chk(n1 - c1, 1);
		end
		// One clock, two enables: counters split over both channels
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_CHAN, 32'h00E4_00A4);
		apb(1'b1, OFF_LE, 32'h0201_0C04);
		le_data[3] <= 4'h3;
		cin <= 1'b1;
		line(4'h4, 1'b1, 8);
		rdchk(OFF_STAT, 32'h3, 32'h1);
		chk(co, 1'b1);
		line(4'h4, 1'b0, 8);
		line(4'h7, 1'b1, 8);
		line(4'h5, 1'b0, 8);
		chk(en1, 1'b0);
		line(4'h4, 1'b1, 8);
		rdchk(OFF_STAT, 32'h3, 32'h3);
		// Carry out of element 3 behind a normal element, then cascade chains through all elements
		le_data[3] <= 4'h1;
		@(posedge clk_i);
		chk(co, 1'b0);
		apb(1'b1, OFF_LE, 32'h0101_0101);
		apb(1'b1, OFF_LUT01, 32'hFFFF_8000);
		apb(1'b1, OFF_LUT23, 32'hFFFF_FFFF);
		le_data[0] <= 4'hF;
		@(posedge clk_i);
		chk(cso, 1'b1);
		le_data[0] <= 4'h0;
		@(posedge clk_i);
		chk(cso, 1'b0);
		summarize();
	end
endmodule
